// file: tb_trigger_routing_matrix.sv
`timescale 1ns/1ns
`include "trm_defines.svh"
module tb_trigger_routing_matrix;
  // ********
  // Signals
  // ********
  logic ref_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [4:0] s_axi_awaddr, s_axi_araddr, opStatusA, opStatusB;
  logic [31:0] s_axi_wdata, s_axi_rdata, firstWidth, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic externalTriggerChannelA_n, externalTriggerChannelB_n, auxiliaryTriggerInput_n;
  logic firstTriggerOutput, firstTriggerOutputEn, secondTriggerOutput, secondTriggerOutputEn;
  logic faultOutput, faultOutputEn, chOutputOnA, chOutputOnB, buttonPress, arbIgnoreTime;
  logic chOnCmdA, chOffCmdA, chOnCmdB, chOffCmdB, logStart, arbStart, arbStep, captureStart;
  logic [2:0] holdLow;
  logic [7:0] acts;
  int mismatches = 0;
  int checked = 0;
  int capCount = 0;
  assign acts = {chOnCmdA, chOffCmdA, chOnCmdB, chOffCmdB, logStart, arbStart, arbStep,
    captureStart};
  trm_matrix trm_matrix_inst (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .externalTriggerChannelA_n, .externalTriggerChannelB_n,
    .auxiliaryTriggerInput_n, .firstTriggerOutput, .firstTriggerOutputEn, .secondTriggerOutput,
    .secondTriggerOutputEn, .faultOutput, .faultOutputEn, .chOutputOnA, .chOutputOnB,
    .opStatusA, .opStatusB, .buttonPress, .chOnCmdA, .chOffCmdA, .chOnCmdB, .chOffCmdB,
    .logStart, .arbStart, .arbStep, .arbIgnoreTime, .captureStart);
  trm_ext_equipment trm_ext_equipment_inst (.ref_clk, .holdLow, .externalTriggerChannelA_n,
    .externalTriggerChannelB_n, .auxiliaryTriggerInput_n, .firstTriggerOutput, .firstWidth);
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (captureStart === 1'h1) capCount <= capCount + 1;
  // ********
  // Helpers
  // ********
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task stop_test;
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task axiWrite(input logic [4:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        rr = s_axi_bresp;
        s_axi_bready <= 1'h0;
        done = 1;
      end
    end
  endtask
  task axiRead(input logic [4:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] s, input logic c, input logic [2:0] m,
    input logic b);
    return {23'h0, b, m, c, s, 1'h1};
  endfunction
  task cfg(input logic [31:0] c, input logic [31:0] o, input logic [31:0] a);
    axiWrite(`TRM_CTRL_OFS, c);
    axiWrite(`TRM_OUTCFG_OFS, o);
    axiWrite(`TRM_ACTCFG_OFS, a);
  endtask
  task pinPulse(input int idx);
    @(posedge ref_clk);
    holdLow[idx] <= 1'h1;
    repeat (3) @(posedge ref_clk);
    holdLow[idx] <= 1'h0;
  endtask
  // Bounded wait, then the whole action set must match
  task expectAct(input logic [7:0] mask, input string name);
    int n;
    n = 0;
    while (acts === 8'h00 && n < 12) begin
      @(posedge ref_clk);
      n++;
    end
    check(name, {24'h0, acts}, {24'h0, mask});
  endtask
  task expectQuiet(input string name);
    logic [7:0] seen;
    seen = 8'h00;
    repeat (10) begin
      @(posedge ref_clk);
      seen = seen | acts;
    end
    check(name, {24'h0, seen}, 32'h0);
  endtask
  // ********
  // Scenarios
  // ********
  task test_bus;
    axiRead(`TRM_CTRL_OFS);
    check("ctrl reset", rd, 32'h0);
    axiRead(5'h18);
    check("unmapped resp", {30'h0, rr}, {30'h0, `TRM_RESP_SLVERR});
    check("unmapped data", rd, 32'h0);
  endtask
  task test_ext_route;
    cfg(ctl(trm_pkg::SRC_EXT_A, 1'h0, 3'h0, 1'h0), 32'h2, 32'h240);
    pinPulse(0);
    expectAct(8'h09, "ext actions");
    check("first_trigger_output pin", {30'h0, firstTriggerOutput, firstTriggerOutputEn}, 32'h3);
    check("second_trigger_output idle", {30'h0, secondTriggerOutput, secondTriggerOutputEn}, 32'h0);
    repeat (`TRM_PULSE_CYC + 4) @(posedge ref_clk);
    check("first_trigger_output width", firstWidth, 32'(`TRM_PULSE_CYC));
  endtask
  task test_disabled;
    cfg(ctl(trm_pkg::SRC_EXT_A, 1'h0, 3'h0, 1'h0) & 32'hffff_fffe, 32'h0, 32'h240);
    pinPulse(0);
    expectQuiet("disabled source");
  endtask
  task test_aux_step;
    cfg(ctl(trm_pkg::SRC_AUX, 1'h0, 3'h0, 1'h0), 32'h0, 32'h100);
    @(posedge ref_clk);
    check("step mode", {31'h0, arbIgnoreTime}, 32'h1);
    for (int i = 0; i < 2; i++) begin
      pinPulse(2);
      expectAct(8'h02, "aux step");
    end
    axiRead(`TRM_STATUS_OFS);
    check("step count", {24'h0, rd[15:8]}, 32'h2);
  endtask
  task test_output_on;
    cfg(ctl(trm_pkg::SRC_OUT_A, 1'h0, 3'h0, 1'h0), 32'h0, 32'h8);
    chOutputOnA <= 1'h1;
    expectAct(8'h20, "output on");
    chOutputOnA <= 1'h0;
  endtask
  task test_opmode;
    cfg(ctl(trm_pkg::SRC_OPMODE, 1'h1, trm_pkg::OPM_SINK, 1'h0), 32'h0, 32'h80);
    opStatusB <= 5'h10;
    expectAct(8'h04, "opmode start");
    opStatusB <= 5'h00;
  endtask
  task test_manual;
    int base;
    base = capCount;
    cfg(ctl(trm_pkg::SRC_MANUAL, 1'h0, 3'h0, 1'h1), 32'h0, 32'h200);
    buttonPress <= 1'h1;
    @(posedge ref_clk);
    buttonPress <= 1'h0;
    axiWrite(`TRM_CMD_OFS, 32'h1);
    repeat (6) @(posedge ref_clk);
    check("manual captures", 32'(capCount - base), 32'h2);
  endtask
  task test_fault;
    cfg(32'h0, 32'hc1, 32'h0);
    opStatusA <= 5'h08;
    repeat (6) @(posedge ref_clk);
    check("fault pin", {30'h0, faultOutput, faultOutputEn}, 32'h3);
    opStatusA <= 5'h00;
  endtask
  task test_second_trigger_output;
    cfg(32'h0, 32'h0, 32'h0);
    axiWrite(`TRM_DIRECT_OFS, 32'hf);
    repeat (2) @(posedge ref_clk);
    check("direct second_trigger_output", {30'h0, secondTriggerOutput, secondTriggerOutputEn}, 32'h3);
    check("direct first_trigger_output", {30'h0, firstTriggerOutput, firstTriggerOutputEn}, 32'h3);
    axiWrite(`TRM_OUTCFG_OFS, 32'h18);
    repeat (2) @(posedge ref_clk);
    check("second_trigger_output armed", {31'h0, secondTriggerOutput}, 32'h0);
    chOutputOnB <= 1'h1;
    repeat (6) @(posedge ref_clk);
    check("second_trigger_output fired", {31'h0, secondTriggerOutput}, 32'h1);
    chOutputOnB <= 1'h0;
  endtask
  task test_gated;
    cfg(ctl(trm_pkg::SRC_EXT_B, 1'h0, 3'h0, 1'h0), 32'h0, 32'h5);
    holdLow[1] <= 1'h1;
    expectAct(8'h80, "gate on");
    repeat (4) @(posedge ref_clk);
    holdLow[1] <= 1'h0;
    expectAct(8'h40, "gate off");
  endtask
  // ********
  // Main sequence
  // ********
  initial begin
    rstn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, opStatusA, opStatusB} = 20'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {chOutputOnA, chOutputOnB, buttonPress, holdLow} = 6'h00;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'h1;
    test_bus();
    test_ext_route();
    test_disabled();
    test_aux_step();
    test_output_on();
    test_opmode();
    test_manual();
    test_fault();
    test_second_trigger_output();
    test_gated();
    stop_test();
  end
  // Run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    stop_test();
  end
endmodule

// file: trm_defines.svh
`ifndef TRM_DEFINES_SVH
`define TRM_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define TRM_CTRL_OFS 5'h00
`define TRM_OUTCFG_OFS 5'h04
`define TRM_ACTCFG_OFS 5'h08
`define TRM_DIRECT_OFS 5'h0c
`define TRM_CMD_OFS 5'h10
`define TRM_STATUS_OFS 5'h14

// ****************************************
// Field positions and masks
// ****************************************
`define TRM_CTRL_MASK 32'h0000_01ff
`define TRM_CTRL_EN 0
`define TRM_CTRL_SRC 1
`define TRM_CTRL_CH 4
`define TRM_CTRL_OPM 5
`define TRM_CTRL_BTN 8
`define TRM_OUTCFG_MASK 32'h0000_01ff
`define TRM_OUT_FAULT_EN 0
`define TRM_OUT_1_EN 1
`define TRM_OUT_1_COND 2
`define TRM_OUT_2_EN 3
`define TRM_OUT_2_COND 4
`define TRM_OUT_FAULT_CH 5
`define TRM_OUT_FAULT_OPM 6
`define TRM_ACTCFG_MASK 32'h0000_03ff
`define TRM_ACT_CHA_EN 0
`define TRM_ACT_CHA_COND 1
`define TRM_ACT_CHB_EN 3
`define TRM_ACT_CHB_COND 4
`define TRM_ACT_LOG_EN 6
`define TRM_ACT_ARB 7
`define TRM_ACT_CAP_EN 9
`define TRM_DIRECT_MASK 32'h0000_000f
`define TRM_DIR_LVL1 0
`define TRM_DIR_LVL2 1
`define TRM_DIR_EN1 2
`define TRM_DIR_EN2 3
`define TRM_CMD_TRG 0
`define TRM_CMD_CLR_LOG 1
`define TRM_CMD_CLR_CAP 2

// ****************************************
// Bus answers and timing
// ****************************************
`define TRM_RESP_OKAY 2'h0
`define TRM_RESP_SLVERR 2'h2
`define TRM_CLK_NS 50
`define TRM_PULSE_NS 1000
`define TRM_PULSE_CYC ((`TRM_PULSE_NS + `TRM_CLK_NS - 1) / `TRM_CLK_NS)

`endif

// file: trm_edge_sync.sv
`timescale 1ns/1ns
module trm_edge_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Active-low pin
  input wire logic pinLow_n,
  // Synchronised view
  output logic asserted,
  output logic assertPulse
);
  logic meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;

  always_comb begin
    meta_d = pinLow_n;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Level comes from the second stage; the pulse also compares it with the third
  assign asserted = !sync_q;
  assign assertPulse = !sync_q && prev_q;
endmodule

// file: trm_ext_equipment.sv
`timescale 1ns/1ns
module trm_ext_equipment (
  // Clock
  input wire logic ref_clk,
  // Bench requests, one bit a line
  input wire logic [2:0] holdLow,
  // Connector pins
  output logic externalTriggerChannelA_n,
  output logic externalTriggerChannelB_n,
  output logic auxiliaryTriggerInput_n,
  input wire logic firstTriggerOutput,
  // Last seen pulse length in cycles
  output logic [31:0] firstWidth
);
  logic [31:0] runLen = 32'h0;
  initial firstWidth = 32'h0;
  // Pulled-up lines: asserting means pulling low
  assign externalTriggerChannelA_n = ~holdLow[0];
  assign externalTriggerChannelB_n = ~holdLow[1];
  assign auxiliaryTriggerInput_n = ~holdLow[2];
  // Retriggers merge into one longer pulse here
  always @(posedge ref_clk) begin
    if (firstTriggerOutput) begin
      runLen <= runLen + 32'h1;
    end else begin
      if (runLen != 32'h0) firstWidth <= runLen;
      runLen <= 32'h0;
    end
  end
endmodule

// file: trm_matrix.sv
`timescale 1ns/1ns
`include "trm_defines.svh"

// Summary of operation
// - Channel A and B external trigger pins assert when pulled low.
// - Auxiliary trigger input asserts when driven low.
// - A detected selected source fires every enabled trigger-out action.
// - Output-on source: a channel output turning on is a trigger event.
// - First output pulses on trigger-in or channel A turning on.
// - Second output pulses on trigger-in or channel B turning on.
// - Channel output target turns on, off or gates on a trigger.
// - Logging target starts the logger on a detected trigger.
// - Sequencer target: start runs whole sequence, step advances one step.
// - Step mode ignores programmed step durations.
// - Capture target starts high-rate capture on a detected trigger.
// - Selected source is ignored unless trigger-in enable is on.
// - Fault, first and second outputs drive only when enabled.
// - Software may set first and second outputs to a level directly.
// - Button press set to trigger, or remote command, is a trigger.
// - One source selected at a time; many actions may respond.
module trm_matrix (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register bus
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Connector pins
  input wire logic externalTriggerChannelA_n,
  input wire logic externalTriggerChannelB_n,
  input wire logic auxiliaryTriggerInput_n,
  output logic firstTriggerOutput,
  output logic firstTriggerOutputEn,
  output logic secondTriggerOutput,
  output logic secondTriggerOutputEn,
  output logic faultOutput,
  output logic faultOutputEn,
  // Instrument state
  input wire logic chOutputOnA,
  input wire logic chOutputOnB,
  input wire logic [4:0] opStatusA,
  input wire logic [4:0] opStatusB,
  input wire logic buttonPress,
  // Instrument actions
  output logic chOnCmdA,
  output logic chOffCmdA,
  output logic chOnCmdB,
  output logic chOffCmdB,
  output logic logStart,
  output logic arbStart,
  output logic arbStep,
  output logic arbIgnoreTime,
  output logic captureStart
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pinRaw_n, pinLevel, pinFall;
  assign pinRaw_n = {auxiliaryTriggerInput_n, externalTriggerChannelB_n,
                     externalTriggerChannelA_n};
  for (genvar g = 0; g < 3; g++) begin : gSync
    trm_edge_sync uSync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .pinLow_n(pinRaw_n[g]),
      .asserted(pinLevel[g]),
      .assertPulse(pinFall[g])
    );
  end

  // ****************************************
  // Bus slave
  // ****************************************
  logic awReady_q, awReady_d, wReady_q, wReady_d, bValid_q, bValid_d;
  logic arReady_q, arReady_d, rValid_q, rValid_d;
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
  logic [4:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d, rData_q, rData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic [31:0] ctrl_q, ctrl_d, outCfg_q, outCfg_d, actCfg_q, actCfg_d;
  logic [31:0] direct_q, direct_d, status;
  logic [2:0] cmd_q, cmd_d;
  logic doWrite;

  function automatic logic [31:0] trmMerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    doWrite = awHeld_q && wHeld_q && !bValid_q;
    awHeld_d = awHeld_q || (s_axi_awvalid && awReady_q);
    wHeld_d = wHeld_q || (s_axi_wvalid && wReady_q);
    awAddr_d = (s_axi_awvalid && awReady_q) ? s_axi_awaddr : awAddr_q;
    wData_d = (s_axi_wvalid && wReady_q) ? s_axi_wdata : wData_q;
    wStrb_d = (s_axi_wvalid && wReady_q) ? s_axi_wstrb : wStrb_q;
    bValid_d = bValid_q && !s_axi_bready;
    bResp_d = bResp_q;
    ctrl_d = ctrl_q;
    outCfg_d = outCfg_q;
    actCfg_d = actCfg_q;
    direct_d = direct_q;
    cmd_d = 3'h0;
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = `TRM_RESP_OKAY;
      unique case (awAddr_q)
        `TRM_CTRL_OFS: ctrl_d = trmMerge(ctrl_q, wData_q, wStrb_q) & `TRM_CTRL_MASK;
        `TRM_OUTCFG_OFS: outCfg_d = trmMerge(outCfg_q, wData_q, wStrb_q) & `TRM_OUTCFG_MASK;
        `TRM_ACTCFG_OFS: actCfg_d = trmMerge(actCfg_q, wData_q, wStrb_q) & `TRM_ACTCFG_MASK;
        `TRM_DIRECT_OFS: direct_d = trmMerge(direct_q, wData_q, wStrb_q) & `TRM_DIRECT_MASK;
        `TRM_CMD_OFS: cmd_d = wStrb_q[0] ? wData_q[2:0] : 3'h0;
        `TRM_STATUS_OFS: bResp_d = `TRM_RESP_OKAY;
        default: bResp_d = `TRM_RESP_SLVERR;
      endcase
    end
    awReady_d = !awHeld_d;
    wReady_d = !wHeld_d;
    rValid_d = rValid_q && !s_axi_rready;
    arReady_d = !rValid_d;
    rData_d = rData_q;
    rResp_d = rResp_q;
    if (s_axi_arvalid && arReady_q) begin
      rValid_d = 1'b1;
      arReady_d = 1'b0;
      rResp_d = `TRM_RESP_OKAY;
      unique case (s_axi_araddr)
        `TRM_CTRL_OFS: rData_d = ctrl_q;
        `TRM_OUTCFG_OFS: rData_d = outCfg_q;
        `TRM_ACTCFG_OFS: rData_d = actCfg_q;
        `TRM_DIRECT_OFS: rData_d = direct_q;
        `TRM_CMD_OFS: rData_d = 32'h0;
        `TRM_STATUS_OFS: rData_d = status;
        default: begin
          rData_d = 32'h0;
          rResp_d = `TRM_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awReady_q <= 1'b1;
      wReady_q <= 1'b1;
      arReady_q <= 1'b1;
      bValid_q <= 1'b0;
      rValid_q <= 1'b0;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bResp_q <= 2'h0;
      rResp_q <= 2'h0;
      awAddr_q <= 5'h00;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      rData_q <= 32'h0;
      ctrl_q <= 32'h0;
      outCfg_q <= 32'h0;
      actCfg_q <= 32'h0;
      direct_q <= 32'h0;
      cmd_q <= 3'h0;
    end else begin
      awReady_q <= awReady_d;
      wReady_q <= wReady_d;
      arReady_q <= arReady_d;
      bValid_q <= bValid_d;
      rValid_q <= rValid_d;
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      bResp_q <= bResp_d;
      rResp_q <= rResp_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      rData_q <= rData_d;
      ctrl_q <= ctrl_d;
      outCfg_q <= outCfg_d;
      actCfg_q <= actCfg_d;
      direct_q <= direct_d;
      cmd_q <= cmd_d;
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  // ****************************************
  // Trigger routing
  // ****************************************
  trm_pkg::trm_source_t src;
  trm_pkg::trm_chcond_t condA, condB;
  trm_pkg::trm_arbmode_t arbMode;
  logic trigEn, srcLevel, srcEvent, trig, opSel, opFault, gate;
  logic [4:0] opMode, faultMode;
  logic [2:0] fire, outEn;
  logic [1:0] chOn_d, chOff_d;
  logic [4:0] opPrevA_q, opPrevA_d, opPrevB_q, opPrevB_d;
  logic [1:0] chPrev_q, chPrev_d;
  logic srcPrev_q, srcPrev_d, gate_q, gate_d, logAct_q, logAct_d, capAct_q, capAct_d;
  logic [4:0] cnt_q [3];
  logic [4:0] cnt_d [3];
  logic [2:0] pin_q, pin_d;
  logic [2:0] act_q, act_d;
  logic [3:0] arb_q, arb_d;
  logic [7:0] stepCnt_q, stepCnt_d;
  logic ignTime_q, ignTime_d;

  always_comb begin
    src = trm_pkg::trm_source_t'(ctrl_q[`TRM_CTRL_SRC +: 3]);
    condA = trm_pkg::trm_chcond_t'(actCfg_q[`TRM_ACT_CHA_COND +: 2]);
    condB = trm_pkg::trm_chcond_t'(actCfg_q[`TRM_ACT_CHB_COND +: 2]);
    arbMode = trm_pkg::trm_arbmode_t'(actCfg_q[`TRM_ACT_ARB +: 2]);
    trigEn = ctrl_q[`TRM_CTRL_EN];
    opMode = 5'h1 << ctrl_q[`TRM_CTRL_OPM +: 3];
    faultMode = 5'h1 << outCfg_q[`TRM_OUT_FAULT_OPM +: 3];
    opSel = ctrl_q[`TRM_CTRL_CH] ? |(opStatusB & opMode) : |(opStatusA & opMode);
    opFault = outCfg_q[`TRM_OUT_FAULT_CH] ? |(opStatusB & ~opPrevB_q & faultMode)
                                          : |(opStatusA & ~opPrevA_q & faultMode);
    // Only one source is looked at, whatever the others do
    unique case (src)
      trm_pkg::SRC_EXT_A: srcLevel = pinLevel[0];
      trm_pkg::SRC_EXT_B: srcLevel = pinLevel[1];
      trm_pkg::SRC_AUX: srcLevel = pinLevel[2];
      trm_pkg::SRC_OUT_A: srcLevel = chOutputOnA;
      trm_pkg::SRC_OUT_B: srcLevel = chOutputOnB;
      trm_pkg::SRC_OPMODE: srcLevel = opSel;
      trm_pkg::SRC_MANUAL: srcLevel = (buttonPress && ctrl_q[`TRM_CTRL_BTN]) ||
                                      cmd_q[`TRM_CMD_TRG];
      default: srcLevel = 1'b0;
    endcase
    // Pin sources use the synchroniser edge; manual ones are pulses already
    unique case (src)
      trm_pkg::SRC_EXT_A: srcEvent = pinFall[0];
      trm_pkg::SRC_EXT_B: srcEvent = pinFall[1];
      trm_pkg::SRC_AUX: srcEvent = pinFall[2];
      trm_pkg::SRC_MANUAL: srcEvent = srcLevel;
      default: srcEvent = srcLevel && !srcPrev_q;
    endcase
    trig = trigEn && srcEvent;
    gate = trigEn && srcLevel;
    srcPrev_d = srcLevel;
    gate_d = gate;
    opPrevA_d = opStatusA;
    opPrevB_d = opStatusB;
    chPrev_d = {chOutputOnB, chOutputOnA};
    fire[0] = opFault;
    fire[1] = outCfg_q[`TRM_OUT_1_COND] ? (chOutputOnA && !chPrev_q[0]) : trig;
    fire[2] = outCfg_q[`TRM_OUT_2_COND] ? (chOutputOnB && !chPrev_q[1]) : trig;
    outEn = {outCfg_q[`TRM_OUT_2_EN], outCfg_q[`TRM_OUT_1_EN], outCfg_q[`TRM_OUT_FAULT_EN]};
    for (int i = 0; i < 3; i++) begin
      // Stretched so slow external equipment sees the pulse
      if (fire[i] && outEn[i]) begin
        cnt_d[i] = 5'(`TRM_PULSE_CYC);
      end else if (cnt_q[i] != 5'h00) begin
        cnt_d[i] = cnt_q[i] - 5'h01;
      end else begin
        cnt_d[i] = 5'h00;
      end
      pin_d[i] = outEn[i] && (cnt_d[i] != 5'h00);
    end
    if (!outEn[1] && direct_q[`TRM_DIR_EN1]) begin
      pin_d[1] = direct_q[`TRM_DIR_LVL1];
    end
    if (!outEn[2] && direct_q[`TRM_DIR_EN2]) begin
      pin_d[2] = direct_q[`TRM_DIR_LVL2];
    end
    act_d = {outEn[2] || direct_q[`TRM_DIR_EN2], outEn[1] || direct_q[`TRM_DIR_EN1],
             outEn[0]};
    chOn_d = 2'h0;
    chOff_d = 2'h0;
    if (actCfg_q[`TRM_ACT_CHA_EN]) begin
      chOn_d[0] = (condA == trm_pkg::CHC_ON) ? trig :
                  (condA == trm_pkg::CHC_GATED) && gate && !gate_q;
      chOff_d[0] = (condA == trm_pkg::CHC_OFF) ? trig :
                   (condA == trm_pkg::CHC_GATED) && !gate && gate_q;
    end
    if (actCfg_q[`TRM_ACT_CHB_EN]) begin
      chOn_d[1] = (condB == trm_pkg::CHC_ON) ? trig :
                  (condB == trm_pkg::CHC_GATED) && gate && !gate_q;
      chOff_d[1] = (condB == trm_pkg::CHC_OFF) ? trig :
                   (condB == trm_pkg::CHC_GATED) && !gate && gate_q;
    end
    // A new start beats a clear in the same cycle
    arb_d[0] = trig && actCfg_q[`TRM_ACT_LOG_EN];
    arb_d[1] = trig && (arbMode == trm_pkg::ARB_START);
    arb_d[2] = trig && (arbMode == trm_pkg::ARB_STEP);
    arb_d[3] = trig && actCfg_q[`TRM_ACT_CAP_EN];
    logAct_d = arb_d[0] || (logAct_q && !cmd_q[`TRM_CMD_CLR_LOG]);
    capAct_d = arb_d[3] || (capAct_q && !cmd_q[`TRM_CMD_CLR_CAP]);
    stepCnt_d = arb_d[2] ? stepCnt_q + 8'h01 : stepCnt_q;
    ignTime_d = (arbMode == trm_pkg::ARB_STEP);
    status = {16'h0, stepCnt_q, 2'h0, pin_q, srcPrev_q, capAct_q, logAct_q};
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      srcPrev_q <= 1'b0;
      gate_q <= 1'b0;
      opPrevA_q <= 5'h00;
      opPrevB_q <= 5'h00;
      chPrev_q <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= 5'h00;
      end
      pin_q <= 3'h0;
      act_q <= 3'h0;
      arb_q <= 4'h0;
      logAct_q <= 1'b0;
      capAct_q <= 1'b0;
      stepCnt_q <= 8'h00;
      ignTime_q <= 1'b0;
      {chOnCmdB, chOnCmdA, chOffCmdB, chOffCmdA} <= 4'h0;
    end else begin
      srcPrev_q <= srcPrev_d;
      gate_q <= gate_d;
      opPrevA_q <= opPrevA_d;
      opPrevB_q <= opPrevB_d;
      chPrev_q <= chPrev_d;
      cnt_q <= cnt_d;
      pin_q <= pin_d;
      act_q <= act_d;
      arb_q <= arb_d;
      logAct_q <= logAct_d;
      capAct_q <= capAct_d;
      stepCnt_q <= stepCnt_d;
      ignTime_q <= ignTime_d;
      {chOnCmdB, chOnCmdA, chOffCmdB, chOffCmdA} <= {chOn_d, chOff_d};
    end
  end

  assign faultOutput = pin_q[0];
  assign firstTriggerOutput = pin_q[1];
  assign secondTriggerOutput = pin_q[2];
  assign faultOutputEn = act_q[0];
  assign firstTriggerOutputEn = act_q[1];
  assign secondTriggerOutputEn = act_q[2];
  assign logStart = arb_q[0];
  assign arbStart = arb_q[1];
  assign arbStep = arb_q[2];
  assign captureStart = arb_q[3];
  assign arbIgnoreTime = ignTime_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_trig_enable_gate: assert property (!trigEn |=> !(logStart || arbStart ||
    arbStep || captureStart)) else $error("trigger without enable");
  a_log_start: assert property (trig && actCfg_q[`TRM_ACT_LOG_EN] |=> logStart && logAct_q)
    else $error("logger not started");
  a_arb_step_only: assert property (trig && arbMode == trm_pkg::ARB_STEP |=> arbStep && !arbStart)
    else $error("step mode misfired");
  a_step_no_time: assert property (arbStep |-> arbIgnoreTime) else $error("step uses time");
  a_capture_start: assert property (trig && actCfg_q[`TRM_ACT_CAP_EN] |=> captureStart)
    else $error("capture not started");
  a_pin_one_pulse: assert property (pinFall[0] |=> !pinFall[0]) else $error("pulse too long");
  a_first_trigger_output_stretch: assert property (fire[1] && outEn[1] |=> firstTriggerOutput [*8])
    else $error("first output pulse short");
  a_fault_quiet: assert property (!outEn[0] |=> !faultOutput) else $error("fault pin drives");
  a_gated_on: assert property (actCfg_q[`TRM_ACT_CHA_EN] && condA == trm_pkg::CHC_GATED &&
    gate && !gate_q |=> chOnCmdA && !chOffCmdA) else $error("gate not followed");
  a_direct_level: assert property (!outEn[1] && direct_q[`TRM_DIR_EN1] |=>
    firstTriggerOutput == $past(direct_q[`TRM_DIR_LVL1])) else $error("direct level lost");
endmodule

// file: trm_pkg.sv
package trm_pkg;
  typedef enum logic [2:0] {
    SRC_EXT_A, SRC_EXT_B, SRC_AUX, SRC_OUT_A, SRC_OUT_B, SRC_OPMODE, SRC_MANUAL
  } trm_source_t;
  typedef enum logic [2:0] {OPM_CC, OPM_CV, OPM_CR, OPM_PROT, OPM_SINK} trm_opmode_t;
  typedef enum logic [1:0] {CHC_ON, CHC_OFF, CHC_GATED} trm_chcond_t;
  typedef enum logic [1:0] {ARB_OFF, ARB_START, ARB_STEP} trm_arbmode_t;
endpackage
